// File: src/chs_setting_regs.sv
// Charger setting register bank with its serial bus slave
`timescale 1ns/1ps
`include "chs_params.svh"

// Contract
// - Options bit 9 enables the switching frequency adjustment chosen by bit 10.
// - Options bits 8:7 pick the high-side short threshold, reset 10.
// - Writing learn bit 1 turns adapter switch off, battery switch on.
// - Depletion reached during learn: swap switches back, clear learn bit.
// - Writing learn bit 0 ends learning; learn bit resets to 0.
// - Options bit 5 routes adapter or charge amplifier to current monitor.
// - Options bits 2:1 set input overcurrent trip level, reset 10.
// - Options bit 0 inhibits charging when set, reset 0.
// - Charge current code sits in bits 12:6, 64 mA per step.
// - Charge current write under 128 mA clears register, stops charging.
// - Charge current setting is zero after reset.
// - Current limit is smaller of register and pin, pin ignored above 1.6V.
// - Charge voltage register, command 0x15, accepts 1.024 to 19.2 V.
// - Charge voltage write out of range clears register, stops charging.
// - Charge voltage setting is zero after reset.
// - Charge voltage code sits in bits 14:4, 16 mV per step.
// - Registers use word write and word read, low byte first.
// - Battery below depletion threshold in learn returns system to adapter.
module chs_setting_regs #(
    parameter logic [6:0] SLAVE_ADDR = `CHS_SLAVE_ADDR
) (
    input  wire logic              CLK_IN,
    input  wire logic              RESET_N_IN,
    input  wire logic              SCL_IN,
    input  wire logic              SDA_IN,
    output logic                   SDA_OUT,
    output logic                   SDA_OE_OUT,
    input  wire logic              BAT_DEPLETED_IN,
    input  wire logic              CURRENT_LIMIT_PIN_HIGH_IN,
    input  wire logic [6:0]        CURRENT_LIMIT_PIN_CODE_IN,
    output chs_pkg::chs_ctrl_t     CTRL_OUT
);
    import chs_pkg::*;

    // ---------------------------------------------------------------
    // Elaboration check
    // ---------------------------------------------------------------
    if (SLAVE_ADDR == 7'h00 || SLAVE_ADDR > 7'h77)
    begin : g_bad_addr
        $error("Slave address is reserved");
    end

    // Code fields must match the widths of the stored settings
    if (`CHS_CUR_MSB - `CHS_CUR_LSB != 6 ||
        `CHS_VOLT_MSB - `CHS_VOLT_LSB != 10)
    begin : g_bad_field
        $error("Code field width differs from stored setting");
    end

    // ---------------------------------------------------------------
    // State record
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0]     scl_s;
        logic [1:0]     sda_s;
        logic [1:0]     depl_s;
        logic [1:0]     lim_hi_s;
        logic [6:0]     lim_code_a;
        logic [6:0]     lim_code_b;
        logic           scl_d;
        logic           sda_d;
        chs_bus_state_t st;
        logic [1:0]     idx;
        logic [3:0]     bits;
        logic [7:0]     sh;
        logic [7:0]     cmd;
        logic [7:0]     lo;
        logic           rd;
        logic           tx_hi;
        logic [15:0]    txw;
        logic           mnack;
        logic           sda_oe;
        logic [15:0]    opt;
        logic [6:0]     cur;
        logic [10:0]    volt;
        chs_ctrl_t      ctrl;
    } chs_state_t;

    chs_state_t s_r;
    chs_state_t s_nxt;

    // ---------------------------------------------------------------
    // Helper functions
    // ---------------------------------------------------------------
    // Word image of a register for read back
    function automatic logic [15:0] read_word(
        input logic [7:0]  c,
        input logic [15:0] o,
        input logic [6:0]  i,
        input logic [10:0] v
    );
        logic [15:0] w;
        w = 16'h0000;
        if (c == `CHS_CMD_OPTIONS)
            w = o & `CHS_OPT_WMASK;
        else if (c == `CHS_CMD_CURRENT)
            w[`CHS_CUR_MSB:`CHS_CUR_LSB] = i;
        else if (c == `CHS_CMD_VOLTAGE)
            w[`CHS_VOLT_MSB:`CHS_VOLT_LSB] = v;
        return w;
    endfunction : read_word

    // Smaller of two current codes
    function automatic logic [6:0] min7(
        input logic [6:0] a,
        input logic [6:0] b
    );
        return (a < b) ? a : b;
    endfunction : min7

    // Voltage code inside its legal window
    function automatic logic volt_ok(
        input logic [10:0] v
    );
        return (v >= `CHS_VOLT_MIN) && (v <= `CHS_VOLT_MAX);
    endfunction : volt_ok

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb
    begin
        logic        rise;
        logic        fall;
        logic        start;
        logic        stop;
        logic [15:0] wd;
        logic [6:0]  ci;
        logic [10:0] cv;
        s_nxt = s_r;
        wd    = {s_r.sh, s_r.lo};
        ci    = wd[`CHS_CUR_MSB:`CHS_CUR_LSB];
        cv    = wd[`CHS_VOLT_MSB:`CHS_VOLT_LSB];

        // Two-flop synchronisers, then edge history
        s_nxt.scl_s      = {s_r.scl_s[0], SCL_IN};
        s_nxt.sda_s      = {s_r.sda_s[0], SDA_IN};
        s_nxt.depl_s     = {s_r.depl_s[0], BAT_DEPLETED_IN};
        s_nxt.lim_hi_s   = {s_r.lim_hi_s[0], CURRENT_LIMIT_PIN_HIGH_IN};
        s_nxt.lim_code_a = CURRENT_LIMIT_PIN_CODE_IN;
        s_nxt.lim_code_b = s_r.lim_code_a;
        s_nxt.scl_d      = s_r.scl_s[1];
        s_nxt.sda_d      = s_r.sda_s[1];

        // Bus clock edges and start, stop conditions
        rise  = s_r.scl_s[1] & ~s_r.scl_d;
        fall  = ~s_r.scl_s[1] & s_r.scl_d;
        start = s_r.scl_s[1] & s_r.scl_d & s_r.sda_d & ~s_r.sda_s[1];
        stop  = s_r.scl_s[1] & s_r.scl_d & ~s_r.sda_d & s_r.sda_s[1];

        // Learn ends by itself once the battery is depleted
        if (s_r.opt[`CHS_OPT_LEARN] && s_r.depl_s[1])
            s_nxt.opt[`CHS_OPT_LEARN] = 1'b0;

        // Serial engine, word transfers low byte first
        if (start)
        begin
            s_nxt.st     = ST_RX;
            s_nxt.idx    = 2'd0;
            s_nxt.bits   = 4'h0;
            s_nxt.sda_oe = 1'b0;
        end
        else if (stop)
        begin
            s_nxt.st     = ST_IDLE;
            s_nxt.sda_oe = 1'b0;
        end
        else
        begin
            case (s_r.st)
                ST_RX:
                begin
                    if (rise && s_r.bits != 4'h8)
                    begin
                        s_nxt.sh   = {s_r.sh[6:0], s_r.sda_s[1]};
                        s_nxt.bits = s_r.bits + 4'h1;
                    end
                    else if (fall && s_r.bits == 4'h8)
                    begin
                        s_nxt.bits   = 4'h0;
                        s_nxt.st     = ST_ACK;
                        s_nxt.sda_oe = 1'b1;
                        if (s_r.idx == 2'd0)
                        begin
                            s_nxt.rd = s_r.sh[0];
                            if (s_r.sh[7:1] != SLAVE_ADDR)
                            begin
                                s_nxt.st     = ST_IDLE;
                                s_nxt.sda_oe = 1'b0;
                            end
                        end
                        else if (s_r.idx == 2'd1)
                            s_nxt.cmd = s_r.sh;
                        else if (s_r.idx == 2'd2)
                            s_nxt.lo = s_r.sh;
                        else
                        begin
                            // Commit of a whole word write
                            if (s_r.cmd == `CHS_CMD_OPTIONS)
                                s_nxt.opt = wd & `CHS_OPT_WMASK;
                            else if (s_r.cmd == `CHS_CMD_CURRENT)
                                s_nxt.cur = (ci < `CHS_CUR_MIN)
                                          ? 7'h00 : ci;
                            else if (s_r.cmd == `CHS_CMD_VOLTAGE)
                                s_nxt.volt = volt_ok(cv)
                                           ? cv : 11'h000;
                        end
                    end
                end
                ST_ACK:
                begin
                    if (fall)
                    begin
                        if (s_r.rd)
                        begin
                            s_nxt.txw    = read_word(s_r.cmd, s_r.opt,
                                                     s_r.cur, s_r.volt);
                            s_nxt.sh     = s_nxt.txw[7:0];
                            s_nxt.tx_hi  = 1'b0;
                            s_nxt.sda_oe = ~s_nxt.txw[7];
                            s_nxt.st     = ST_TX;
                        end
                        else
                        begin
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.st     = (s_r.idx == 2'd3) ? ST_IDLE
                                                             : ST_RX;
                            s_nxt.idx    = s_r.idx + 2'd1;
                        end
                    end
                end
                ST_TX:
                begin
                    // Next read bit goes out just after a clock fall
                    if (fall)
                    begin
                        if (s_r.bits == 4'h7)
                        begin
                            s_nxt.bits   = 4'h0;
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.st     = ST_MACK;
                        end
                        else
                        begin
                            s_nxt.bits   = s_r.bits + 4'h1;
                            s_nxt.sh     = {s_r.sh[6:0], 1'b0};
                            s_nxt.sda_oe = ~s_r.sh[6];
                        end
                    end
                end
                ST_MACK:
                begin
                    if (rise)
                        s_nxt.mnack = s_r.sda_s[1];
                    else if (fall)
                    begin
                        if (!s_r.mnack && !s_r.tx_hi)
                        begin
                            s_nxt.tx_hi  = 1'b1;
                            s_nxt.sh     = s_r.txw[15:8];
                            s_nxt.sda_oe = ~s_r.txw[15];
                            s_nxt.st     = ST_TX;
                        end
                        else
                            s_nxt.st = ST_IDLE;
                    end
                end
                default:
                begin
                    s_nxt.st     = ST_IDLE;
                    s_nxt.sda_oe = 1'b0;
                end
            endcase
        end

        // Registered outputs toward converter and switches
        s_nxt.ctrl.freq_adj_en  = s_r.opt[`CHS_OPT_FREQ_EN];
        s_nxt.ctrl.freq_up      = s_r.opt[`CHS_OPT_FREQ_EN] &
                                  s_r.opt[`CHS_OPT_FREQ_UP];
        s_nxt.ctrl.hs_short_thr =
            s_r.opt[`CHS_OPT_HS_MSB:`CHS_OPT_HS_LSB];
        s_nxt.ctrl.depl_sel     =
            s_r.opt[`CHS_OPT_DEPL_MSB:`CHS_OPT_DEPL_LSB];
        s_nxt.ctrl.battery_switch_on  = s_r.opt[`CHS_OPT_LEARN];
        s_nxt.ctrl.adapter_switch_on  = ~s_r.opt[`CHS_OPT_LEARN];
        s_nxt.ctrl.monitor_sel  = s_r.opt[`CHS_OPT_MON_SEL];
        s_nxt.ctrl.oc_trip      =
            s_r.opt[`CHS_OPT_OC_MSB:`CHS_OPT_OC_LSB];
        s_nxt.ctrl.inhibit      = s_r.opt[`CHS_OPT_INHIBIT];
        s_nxt.ctrl.current_code = s_r.cur;
        s_nxt.ctrl.voltage_code = s_r.volt;
        s_nxt.ctrl.current_limit = s_r.lim_hi_s[1] ? s_r.cur
                                 : min7(s_r.cur, s_r.lim_code_b);
        s_nxt.ctrl.permit       = ~s_r.opt[`CHS_OPT_INHIBIT] &
                                  (s_r.cur != 7'h00) &
                                  (s_r.volt != 11'h000);
        s_nxt.ctrl.converter_en = s_r.ctrl.permit;
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            s_r      <= '0;
            s_r.st   <= ST_IDLE;
            s_r.scl_s <= 2'b11;
            s_r.sda_s <= 2'b11;
            s_r.scl_d <= 1'b1;
            s_r.sda_d <= 1'b1;
            // Power-on register contents
            s_r.opt  <= `CHS_OPT_RESET;
            s_r.cur  <= `CHS_CUR_RESET;
            s_r.volt <= `CHS_VOLT_RESET;
            // Outputs start from the power-on settings
            s_r.ctrl.hs_short_thr      <= 2'b10;
            s_r.ctrl.depl_sel          <= 2'b11;
            s_r.ctrl.adapter_switch_on <= 1'b1;
            s_r.ctrl.oc_trip           <= 2'b10;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs straight from flops, except data out tied low
    // ---------------------------------------------------------------
    assign SDA_OUT    = 1'b0;        // Open drain, only pulls low
    assign SDA_OE_OUT = s_r.sda_oe;
    assign CTRL_OUT   = s_r.ctrl;

endmodule : chs_setting_regs

// File: src/chs_params.svh
// Constants for the charger setting register bank
`ifndef CHS_PARAMS_SVH
`define CHS_PARAMS_SVH

// ---------------------------------------------------------------
// Serial bus addressing
// ---------------------------------------------------------------
`define CHS_SLAVE_ADDR     7'h09
`define CHS_CMD_OPTIONS    8'h12
`define CHS_CMD_CURRENT    8'h14
`define CHS_CMD_VOLTAGE    8'h15

// ---------------------------------------------------------------
// Reset values and masks
// ---------------------------------------------------------------
`define CHS_OPT_RESET      16'h7904
`define CHS_OPT_WMASK      16'hFFE7
`define CHS_CUR_RESET      7'h00
`define CHS_VOLT_RESET     11'h000

// ---------------------------------------------------------------
// Field positions in the options word
// ---------------------------------------------------------------
`define CHS_OPT_INHIBIT    0
`define CHS_OPT_OC_LSB     1
`define CHS_OPT_OC_MSB     2
`define CHS_OPT_MON_SEL    5
`define CHS_OPT_LEARN      6
`define CHS_OPT_HS_LSB     7
`define CHS_OPT_HS_MSB     8
`define CHS_OPT_FREQ_EN    9
`define CHS_OPT_FREQ_UP    10
`define CHS_OPT_DEPL_LSB   11
`define CHS_OPT_DEPL_MSB   12

// ---------------------------------------------------------------
// Code fields and their legal ranges
// ---------------------------------------------------------------
`define CHS_CUR_LSB        6
`define CHS_CUR_MSB        12
`define CHS_VOLT_LSB       4
`define CHS_VOLT_MSB       14
`define CHS_CUR_MIN        7'h02
`define CHS_VOLT_MIN       11'h040
`define CHS_VOLT_MAX       11'h4B0

`endif

// File: src/chs_pkg.sv
// Types shared by the charger setting register bank
package chs_pkg;

    // Serial engine states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX   = 5'h02,
        ST_ACK  = 5'h04,
        ST_TX   = 5'h08,
        ST_MACK = 5'h10
    } chs_bus_state_t;

    // Settings as seen by the converter and switch logic
    typedef struct packed {
        logic        freq_adj_en;
        logic        freq_up;
        logic [1:0]  hs_short_thr;
        logic [1:0]  depl_sel;
        logic        adapter_switch_on;
        logic        battery_switch_on;
        logic        monitor_sel;
        logic [1:0]  oc_trip;
        logic        inhibit;
        logic [6:0]  current_code;
        logic [10:0] voltage_code;
        logic [6:0]  current_limit;
        logic        permit;
        logic        converter_en;
    } chs_ctrl_t;

endpackage : chs_pkg

// File: verif/chs_regs_monitor.sv
// Port assertions for the charger setting register bank
`timescale 1ns/1ps
module chs_regs_monitor (
    input wire logic               CLK_IN,
    input wire logic               RESET_N_IN,
    input wire logic               SCL_IN,
    input wire logic               SDA_IN,
    input wire logic               SDA_OUT,
    input wire logic               SDA_OE_OUT,
    input wire logic               BAT_DEPLETED_IN,
    input wire logic               CURRENT_LIMIT_PIN_HIGH_IN,
    input wire logic [6:0]         CURRENT_LIMIT_PIN_CODE_IN,
    input wire chs_pkg::chs_ctrl_t CTRL_OUT
);
    import chs_pkg::*;
    // ------------------------------------------------------------
    // Settings, switches and data pin behaviour
    // ------------------------------------------------------------
    default clocking mon_cb @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    AST_RESET_VAL: assert property (
        $rose(RESET_N_IN) |-> CTRL_OUT.hs_short_thr == 2'h2
        && CTRL_OUT.oc_trip == 2'h2 && CTRL_OUT.adapter_switch_on
        && !CTRL_OUT.inhibit && !CTRL_OUT.freq_adj_en
        && CTRL_OUT.current_code == 7'h00 && CTRL_OUT.voltage_code == 11'h000)
        else $error("Setting differs from power-on value");
    AST_SWITCH_PAIR: assert property (
        CTRL_OUT.adapter_switch_on != CTRL_OUT.battery_switch_on)
        else $error("Power switches not complementary");
    AST_FREQ_GATE: assert property (
        CTRL_OUT.freq_up |-> CTRL_OUT.freq_adj_en)
        else $error("Frequency adjust active while disabled");
    AST_PERMIT: assert property (
        CTRL_OUT.permit == (!CTRL_OUT.inhibit && CTRL_OUT.current_code != 7'h00
        && CTRL_OUT.voltage_code != 11'h000))
        else $error("Charge permit wrong");
    AST_CONV_EN: assert property (
        1'b1 |=> CTRL_OUT.converter_en == $past(CTRL_OUT.permit))
        else $error("Converter enable does not follow permit");
    AST_CODE_RANGE: assert property (
        CTRL_OUT.current_code != 7'h01 && (CTRL_OUT.voltage_code == 11'h000
        || (CTRL_OUT.voltage_code >= 11'h040 && CTRL_OUT.voltage_code <= 11'h4B0)))
        else $error("Setting code outside its range");
    AST_LIMIT_MIN: assert property (
        CTRL_OUT.current_limit <= CTRL_OUT.current_code)
        else $error("Current limit above setting");
    AST_LIMIT_OFF: assert property (
        CURRENT_LIMIT_PIN_HIGH_IN[*4] |-> CTRL_OUT.current_limit
        == CTRL_OUT.current_code)
        else $error("Limit pin not ignored while high");
    AST_LEARN_END: assert property (
        (CTRL_OUT.battery_switch_on && BAT_DEPLETED_IN)[*2]
        |-> ##[1:5] !CTRL_OUT.battery_switch_on)
        else $error("Learn cycle not ended on depletion");
    AST_SDA_HOLD: assert property (
        SCL_IN[*2] |-> $stable(SDA_OE_OUT))
        else $error("Data pin changed while bus clock high");
    COV_LEARN: cover property (CTRL_OUT.battery_switch_on ##1
        !CTRL_OUT.battery_switch_on);
    COV_PERMIT: cover property ($rose(CTRL_OUT.permit));
    COV_LIMIT: cover property (CTRL_OUT.current_limit < CTRL_OUT.current_code);
endmodule : chs_regs_monitor

bind chs_setting_regs chs_regs_monitor i_chs_regs_monitor (
    .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .SCL_IN(SCL_IN),
    .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT),
    .BAT_DEPLETED_IN(BAT_DEPLETED_IN),
    .CURRENT_LIMIT_PIN_HIGH_IN(CURRENT_LIMIT_PIN_HIGH_IN),
    .CURRENT_LIMIT_PIN_CODE_IN(CURRENT_LIMIT_PIN_CODE_IN),
    .CTRL_OUT(CTRL_OUT)
);

// File: verif/chs_host_model.sv
// Bus host model that writes and reads the setting registers
`timescale 1ns/1ps
module chs_host_model (
    input  wire logic CLK_IN,
    input  wire logic sda_line_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    // ------------------------------------------------------------
    // Bit, byte and frame tasks; bus clock stands high when idle
    // ------------------------------------------------------------
    logic ph;
    initial
    begin
        scl_out     = 1'b1;
        sda_low_out = 1'b0;
        ph          = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge CLK_IN);
    endtask : wt
    // Data moves only while the clock is low; 12 or 13 clocks a bit
    task automatic bit_x(input logic b, output logic r);
        wt(3);
        sda_low_out <= !b;
        ph = !ph;
        wt(3 + int'(ph));
        scl_out <= 1'b1;
        wt(6);
        r = sda_line_in;
        scl_out <= 1'b0;
    endtask : bit_x
    task automatic start_c();
        wt(4);
        sda_low_out <= 1'b0;
        wt(4);
        scl_out <= 1'b1;
        wt(4);
        sda_low_out <= 1'b1;
        wt(4);
        scl_out <= 1'b0;
    endtask : start_c
    task automatic stop_c();
        wt(4);
        sda_low_out <= 1'b1;
        wt(4);
        scl_out <= 1'b1;
        wt(4);
        sda_low_out <= 1'b0;
        wt(4);
    endtask : stop_c
    // Byte MSB first, then the answer bit; low answer counts as ack
    task automatic tx_byte(input logic [7:0] d, inout int acks);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], r);
        bit_x(1'b1, r);
        acks += int'(!r);
    endtask : tx_byte
    task automatic rx_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, d[i]);
        bit_x(nack, r);
    endtask : rx_byte
    // Word write, low byte first; nb below 2 cuts the frame short
    task automatic write_word(input logic [6:0] a, input logic [7:0] c,
        input logic [15:0] d, input int nb, output int acks);
        acks = 0;
        start_c();
        tx_byte({a, 1'b0}, acks);
        tx_byte(c, acks);
        if (nb > 0)
            tx_byte(d[7:0], acks);
        if (nb > 1)
            tx_byte(d[15:8], acks);
        stop_c();
    endtask : write_word
    // Word read: command, repeated start, low then high byte
    task automatic read_word(input logic [6:0] a, input logic [7:0] c,
        output logic [15:0] d, output int acks);
        acks = 0;
        start_c();
        tx_byte({a, 1'b0}, acks);
        tx_byte(c, acks);
        start_c();
        tx_byte({a, 1'b1}, acks);
        rx_byte(1'b0, d[7:0]);
        rx_byte(1'b1, d[15:8]);
        stop_c();
    endtask : read_word
endmodule : chs_host_model

// File: verif/tb_top.sv
// Self-checking bench for the charger setting register bank
`timescale 1ns/1ps
`include "chs_params.svh"
module tb_top;
    import chs_pkg::*;
    // ------------------------------------------------------------
    // Pins, open-drain data wire and reference registers
    // ------------------------------------------------------------
    logic       clk, rst_n, scl, sda_low, sda_line, sda_out, sda_oe, dep;
    logic       lim_hi;
    logic [6:0] lim_code;
    chs_ctrl_t  ctrl;
    int         err_total, total_checks, m_opt, m_cur, m_volt, acks, seed;
    logic [7:0] cmds [4] = '{8'h12, 8'h14, 8'h15, 8'h3F};
    logic [7:0] t_cmd [12] = '{8'h14, 8'h14, 8'h14, 8'h15, 8'h15, 8'h15,
        8'h15, 8'h15, 8'h15, 8'h12, 8'h12, 8'h12};
    logic [15:0] t_dat [12] = '{16'h0040, 16'h0080, 16'hFFFF, 16'h03F0,
        16'h0400, 16'h4B0F, 16'h4B10, 16'hFFFF, 16'h4B00, 16'hFFFF,
        16'h0040, 16'h0000};

    always #5 clk = !clk;
    assign sda_line = (sda_oe ? sda_out : 1'b1) & !sda_low;

    chs_setting_regs i_chs_setting_regs (
        .CLK_IN(clk), .RESET_N_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda_line),
        .SDA_OUT(sda_out), .SDA_OE_OUT(sda_oe), .BAT_DEPLETED_IN(dep),
        .CURRENT_LIMIT_PIN_HIGH_IN(lim_hi),
        .CURRENT_LIMIT_PIN_CODE_IN(lim_code), .CTRL_OUT(ctrl));
    chs_host_model i_host (.CLK_IN(clk), .sda_line_in(sda_line),
        .scl_out(scl), .sda_low_out(sda_low));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Reference outputs from the modelled registers
    function automatic chs_ctrl_t exp_ctrl();
        chs_ctrl_t e;
        int        cc, vc;
        cc = (m_cur >> 6) & 127;
        vc = (m_volt >> 4) & 2047;
        e = '{m_opt[9], m_opt[9] & m_opt[10], m_opt[8:7], m_opt[12:11],
            !m_opt[6], m_opt[6], m_opt[5], m_opt[2:1], m_opt[0], 7'(cc),
            11'(vc), (lim_hi || cc < lim_code) ? 7'(cc) : lim_code,
            !m_opt[0] && cc != 0 && vc != 0, 1'b0};
        e.converter_en = e.permit;
        return e;
    endfunction : exp_ctrl
    function automatic int reg_of(input logic [7:0] c);
        return (c == 8'h12) ? m_opt : (c == 8'h14) ? m_cur :
            (c == 8'h15) ? m_volt : 0;
    endfunction : reg_of
    // Out-of-range settings are stored as zero
    task automatic model_wr(input logic [7:0] c, input int d);
        int vc;
        vc = (d >> 4) & 2047;
        if (c == 8'h12)
            m_opt = d & 16'hFFE7;
        if (c == 8'h14)
            m_cur = (((d >> 6) & 127) < 2) ? 0 : d & 16'h1FC0;
        if (c == 8'h15)
            m_volt = (vc < 64 || vc > 1200) ? 0 : d & 16'h7FF0;
    endtask : model_wr
    task automatic ctrl_chk();
        @(posedge clk);
        check(64'(ctrl), 64'(exp_ctrl()));
    endtask : ctrl_chk
    task automatic rd_chk(input logic [7:0] c, input int exp);
        logic [15:0] v;
        int          k;
        i_host.read_word(`CHS_SLAVE_ADDR, c, v, k);
        check(64'(k), 64'd3);
        check(64'(v), 64'(exp[15:0]));
    endtask : rd_chk
    task automatic wr_chk(input logic [7:0] c, input logic [15:0] d);
        int k;
        i_host.write_word(`CHS_SLAVE_ADDR, c, d, 2, k);
        check(64'(k), 64'd4);
        model_wr(c, int'(d));
        rd_chk(c, reg_of(c));
        ctrl_chk();
    endtask : wr_chk
    task automatic finish_test();
        $display("Checks %0d, errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0; rst_n = 1'b0; dep = 1'b0; lim_hi = 1'b1; lim_code = 7'h00;
        err_total = 0; total_checks = 0; m_opt = 16'h7904; m_cur = 0; m_volt = 0;
        seed = $urandom(32'h33DD);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        ctrl_chk();
        for (int i = 0; i < 4; i++)
            rd_chk(cmds[i], reg_of(cmds[i]));
        for (int i = 0; i < 12; i++)
            wr_chk(t_cmd[i], t_dat[i]);
        repeat (24)
        begin
            lim_hi <= 1'($urandom);
            lim_code <= 7'($urandom);
            wr_chk(cmds[$urandom % 4], 16'($urandom));
        end
        // Learn cycle ended by a depleted battery
        wr_chk(8'h12, 16'h0040);
        dep <= 1'b1;
        repeat (8) @(posedge clk);
        m_opt[6] = 1'b0;
        dep <= 1'b0;
        ctrl_chk();
        rd_chk(8'h12, m_opt);
        // Foreign address and a frame cut short change nothing
        i_host.write_word(`CHS_SLAVE_ADDR ^ 7'h01, 8'h14, 16'h0100, 2, acks);
        check(64'(acks), 64'd0);
        i_host.write_word(`CHS_SLAVE_ADDR, 8'h14, 16'h0100, 1, acks);
        check(64'(acks), 64'd3);
        rd_chk(8'h14, m_cur);
        finish_test();
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        err_total++;
        $display("[ERR] %0t run did not complete", $time);
        finish_test();
    end
endmodule : tb_top
